// ===== inc/can_consts.vh
`ifndef CAN_CONSTS_VH
`define CAN_CONSTS_VH

// ==========================================================
// Register indices (byte address = index * 4)
`define IDX_MODE_CTRL   6'h00
`define IDX_MODE_STAT   6'h01
`define IDX_SEND_FLAGS  6'h06
`define IDX_ABORT_REQ   6'h08
`define IDX_ABORT_DONE  6'h09
`define IDX_SEND_SELECT 6'h0a
`define IDX_ACC_CTRL    6'h0b
`define IDX_TEST_0      6'h0c
`define IDX_TEST_1      6'h0d
`define IDX_RX_ERR      6'h0e
`define IDX_TX_ERR      6'h0f
`define IDX_MASK_0      6'h14
`define IDX_MASK_1      6'h15
`define IDX_MASK_2      6'h16
`define IDX_MASK_3      6'h17
`define IDX_CODE_5      6'h19
`define IDX_CODE_6      6'h1a
`define IDX_CODE_7      6'h1b

// ==========================================================
// Address field split
`define IDX_HI          7
`define IDX_LO          2
`define FILT_SPACE      2'b01
`define WIN_SPACE       2'b10
`define WIN_IDX_W       4

// ==========================================================
// Field positions
`define CTRL_INIT_BIT   0
`define CTRL_SLEEP_BIT  1
`define STAT_INIT_BIT   0
`define STAT_SLEEP_BIT  1
`define ACC_MODE_HI     5
`define ACC_MODE_LO     4
`define ACC_HIT_HI      2
`define ACC_HIT_LO      0

// ==========================================================
// Filter modes
`define FMODE_32        2'h0
`define FMODE_16        2'h1
`define FMODE_8         2'h2
`define FMODE_CLOSED    2'h3

// ==========================================================
// Reset values
`define BYTE_RST        8'h00
`define SEND_FLAGS_RST  3'h7
`define THREE_ZERO      3'h0

`endif

// ===== testbench/can_filter_sva.sv
`timescale 1ns/1ns

// ==========================================================
// Port checker: bus answer, read rules, receive loading
module can_filter_sva (
    // Clock and reset
    input wire        clk_i,
    input wire        rst_i,
    // Bus
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [7:0]  adr_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    // Device side
    input wire [2:0]  tx_done_i,
    input wire [2:0]  tx_pending_o,
    input wire        rx_valid_i,
    input wire [31:0] rx_ident_i,
    input wire [7:0]  rx_err_count_i,
    input wire [31:0] rx_back_ident_o,
    input wire [31:0] rx_front_ident_o,
    input wire        rx_accept_o,
    input wire        init_mode_o,
    input wire        sleep_mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A read answer is judged in its ack cycle, address still held
    wire rd_ack = ack_o && !we_i;

    AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack too long");
    AST_SEL_LOWEST: assert property (rd_ack && adr_i == 8'h28 |-> $onehot0(dat_o[7:0]))
        else $error("select read has several bits");
    AST_TEST_ZERO: assert property (rd_ack && adr_i[7:3] == 5'h06 |-> dat_o == 32'h0000_0000)
        else $error("test register not zero");
    AST_ERR_HIDDEN: assert property (rd_ack && adr_i[7:3] == 5'h07 && !init_mode_o && !sleep_mode_o
        |-> dat_o == 32'h0000_0000) else $error("error count visible");
    AST_ERR_SHOWN: assert property (rd_ack && adr_i == 8'h38 && init_mode_o
        |-> dat_o[7:0] == $past(rx_err_count_i)) else $error("error count wrong");
    AST_INIT_HOLD: assert property (rd_ack && init_mode_o && $past(init_mode_o)
        && (adr_i == 8'h24 || adr_i == 8'h28) |-> dat_o == 32'h0000_0000) else $error("not held in init");
    AST_BACK_LOAD: assert property ($past(rx_valid_i) |-> rx_back_ident_o == $past(rx_ident_i))
        else $error("background not loaded");
    AST_FRONT_LOAD: assert property (rx_accept_o |-> $past(rx_valid_i)
        && rx_front_ident_o == $past(rx_ident_i)) else $error("front load wrong");
    AST_DONE_EMPTY: assert property (tx_done_i != 3'h0
        |-> ##2 (tx_pending_o & $past(tx_done_i, 2)) == 3'h0) else $error("sent buffer still pending");
    // Main scenarios reached
    cover property (rx_accept_o);
    cover property (ack_o && we_i);
    cover property (tx_done_i != 3'h0);
endmodule // can_filter_sva

bind can_txsel_acceptance_filter can_filter_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .tx_done_i(tx_done_i),
    .tx_pending_o(tx_pending_o), .rx_valid_i(rx_valid_i), .rx_ident_i(rx_ident_i),
    .rx_err_count_i(rx_err_count_i), .rx_back_ident_o(rx_back_ident_o),
    .rx_front_ident_o(rx_front_ident_o), .rx_accept_o(rx_accept_o), .init_mode_o(init_mode_o),
    .sleep_mode_o(sleep_mode_o));

// ===== testbench/can_node_model.sv
`timescale 1ns/1ns

// ==========================================================
// Far side: bus traffic and transmit progress
module can_node_model (
    // Clock
    input  wire         clk_i,
    // Received frames
    output logic        rx_valid_o,
    output wire  [31:0] rx_ident_o,
    output wire         rx_ext_o,
    // Transmit progress
    output logic [2:0]  tx_done_o,
    output logic [2:0]  tx_busy_o,
    output logic [2:0]  tx_fail_o
);
    logic [31:0] frame_id;
    logic        frame_ext;
    logic [31:0] noise = 32'h1357_9bdf;

    initial begin
        rx_valid_o = 1'b0;
        tx_done_o  = 3'h0;
        tx_busy_o  = 3'h0;
        tx_fail_o  = 3'h0;
    end
    // Outside a frame the lines churn, so a stale ident never matches
    always @(posedge clk_i) begin
        noise <= {noise[30:0], noise[31] ^ noise[21] ^ noise[1] ^ noise[0]};
    end
    assign rx_ident_o = rx_valid_o ? frame_id : noise;
    assign rx_ext_o   = rx_valid_o ? frame_ext : noise[3];

    // Every frame on the wire is handed over, accepted or not
    task automatic frame(input logic [31:0] id, input logic ext);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        frame_id   <= id;
        frame_ext  <= ext;
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
    endtask

    // Start, then finish with success or a lost arbitration
    task automatic tx_start(input int k);
        @(posedge clk_i);
        tx_busy_o[k] <= 1'b1;
    endtask
    task automatic tx_end(input int k, input logic ok);
        @(posedge clk_i);
        tx_busy_o[k] <= 1'b0;
        tx_done_o[k] <= ok;
        tx_fail_o[k] <= !ok;
        @(posedge clk_i);
        tx_done_o <= 3'h0;
        tx_fail_o <= 3'h0;
    endtask
endmodule // can_node_model

// ===== testbench/testbench.sv
`timescale 1ns/1ns

// ==========================================================
// Bench top
module testbench;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00, rx_err_count_i = 8'h00, tx_err_count_i = 8'h00, q;
    logic [31:0] dat_i = 32'h0, id, front = 32'h0;
    logic [5:0]  tx_rd_addr_i = 6'h00;
    wire  [31:0] dat_o, rx_ident_i, rx_back_ident_o, rx_front_ident_o;
    wire  [7:0]  tx_rd_data_o;
    wire  [2:0]  tx_done_i, tx_busy_i, tx_fail_i, tx_pending_o;
    wire         ack_o, rx_valid_i, rx_ext_i, rx_accept_o, init_mode_o, sleep_mode_o;
    logic [7:0]  code [8], mask [8];
    int          miscompares = 0, tests_run = 0, mode = 0, hit = 0, h, i, m, p;
    logic        ext;

    always #50 clk_i = ~clk_i;

    can_txsel_acceptance_filter u_can_txsel_acceptance_filter (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .tx_done_i(tx_done_i), .tx_busy_i(tx_busy_i), .tx_fail_i(tx_fail_i), .tx_rd_addr_i(tx_rd_addr_i),
        .tx_rd_data_o(tx_rd_data_o), .tx_pending_o(tx_pending_o), .rx_valid_i(rx_valid_i),
        .rx_ident_i(rx_ident_i), .rx_ext_i(rx_ext_i), .rx_back_ident_o(rx_back_ident_o),
        .rx_front_ident_o(rx_front_ident_o), .rx_accept_o(rx_accept_o), .rx_err_count_i(rx_err_count_i),
        .tx_err_count_i(tx_err_count_i), .init_mode_o(init_mode_o), .sleep_mode_o(sleep_mode_o));
    can_node_model u_can_node_model (.clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_ident_o(rx_ident_i),
        .rx_ext_o(rx_ext_i), .tx_done_o(tx_done_i), .tx_busy_o(tx_busy_i), .tx_fail_o(tx_fail_i));

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // Classic cycle: hold until ack is sampled, then release
    task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 2'b00, 24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (n >= 20) miscompares++;
        q = dat_o[7:0];
        {cyc_i, stb_i} <= 2'b00;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), {24'h0, e}, {24'h0, q});
    endtask
    task automatic peek(input logic [1:0] b, input logic [7:0] e);
        tx_rd_addr_i <= {b, 4'h0};
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk("buffer byte", {24'h0, e}, {24'h0, tx_rd_data_o});
    endtask
    // Reference filter: lowest matching filter or -1
    function automatic int find_hit(input logic [31:0] v, input logic x);
        int f, k, w, nb;
        w = (mode == 0) ? 4 : (mode == 1) ? 2 : 1;
        nb = (mode == 0) ? (x ? 4 : 2) : w;
        if (mode == 3) return -1;
        for (f = 0; f < 8 / w; f++) begin
            for (k = 0; k < nb; k++) if (((code[f*w+k] ^ v[31-8*k -: 8]) & ~mask[f*w+k]) != 8'h00) break;
            if (k == nb) return f;
        end
        return -1;
    endfunction

    initial begin
        #3_000_000;
        miscompares++;
        report_and_stop;
    end
    // ==========================================================
    // Main sequence
    initial begin
        p = $urandom(62);
        rx_err_count_i <= $urandom;
        tx_err_count_i <= $urandom;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 16; i < 32; i++) rd(i, 8'h00);
        rd(6'h0b, 8'h00);
        rd(6'h3f, 8'h00);
        wb(1'b1, 6'h14, 8'h5a);
        rd(6'h14, 8'h00);
        rd(6'h0e, 8'h00);
        rd(6'h0f, 8'h00);
        wb(1'b1, 6'h0c, 8'hff);
        rd(6'h0c, 8'h00);
        for (i = 0; i < 8; i++) begin
            wb(1'b1, 6'h0a, i);
            rd(6'h0a, i & -i);
        end
        // Two buffers through one window
        wb(1'b1, 6'h0a, 8'h03);
        wb(1'b1, 6'h20, 8'ha5);
        wb(1'b1, 6'h0a, 8'h02);
        wb(1'b1, 6'h20, 8'h3c);
        wb(1'b1, 6'h0a, 8'h05);
        rd(6'h20, 8'ha5);
        peek(2'd1, 8'h3c);
        wb(1'b1, 6'h0a, 8'h00);
        rd(6'h20, 8'h00);
        wb(1'b1, 6'h20, 8'h77);
        peek(2'd0, 8'ha5);
        // Scheduled buffer: window blocked, abort while on the wire
        wb(1'b1, 6'h06, 8'h01);
        wb(1'b1, 6'h0a, 8'h01);
        chk("pending", 32'h1, {29'h0, tx_pending_o});
        rd(6'h20, 8'h00);
        wb(1'b1, 6'h20, 8'h77);
        peek(2'd0, 8'ha5);
        u_can_node_model.tx_start(0);
        wb(1'b1, 6'h08, 8'h01);
        rd(6'h06, 8'h06);
        u_can_node_model.tx_end(0, 1'b0);
        rd(6'h06, 8'h07);
        rd(6'h09, 8'h01);
        wb(1'b1, 6'h09, 8'h00);
        rd(6'h09, 8'h01);
        wb(1'b1, 6'h06, 8'h01);
        rd(6'h09, 8'h00);
        u_can_node_model.tx_start(0);
        wb(1'b1, 6'h08, 8'h01);
        u_can_node_model.tx_end(0, 1'b1);
        rd(6'h06, 8'h07);
        rd(6'h09, 8'h00);
        // Init mode holds the select register
        wb(1'b1, 6'h0a, 8'h04);
        wb(1'b1, 6'h00, 8'h01);
        rd(6'h01, 8'h01);
        chk("init mode", 32'h1, {31'h0, init_mode_o});
        rd(6'h0a, 8'h00);
        wb(1'b1, 6'h0a, 8'h01);
        rd(6'h0a, 8'h00);
        wb(1'b1, 6'h0e, 8'h00);
        rd(6'h0e, rx_err_count_i);
        rd(6'h0f, tx_err_count_i);
        // Sleep shows the counts too; select writable again once init is left
        wb(1'b1, 6'h00, 8'h02);
        rd(6'h01, 8'h02);
        chk("sleep mode", 32'h1, {31'h0, sleep_mode_o});
        rd(6'h0e, rx_err_count_i);
        wb(1'b1, 6'h0a, 8'h06);
        rd(6'h0a, 8'h02);
        // Every filter mode, programmed in init and run outside it
        for (m = 0; m < 4; m++) begin
            wb(1'b1, 6'h00, 8'h01);
            for (i = 0; i < 8; i++) {code[i], mask[i]} = {$urandom, $urandom | $urandom} & 16'hffff;
            if (m == 0) {mask[1][2:0], mask[5][2:0]} = 6'h3f;
            if (m == 1) {mask[5][2:0], mask[7][2:0]} = 6'h3f;
            for (i = 0; i < 8; i++) begin
                wb(1'b1, (i < 4) ? 16 + i : 20 + i, code[i]);
                wb(1'b1, (i < 4) ? 20 + i : 24 + i, mask[i]);
                rd((i < 4) ? 20 + i : 24 + i, mask[i]);
            end
            mode = m;
            wb(1'b1, 6'h0b, {2'b00, m[1:0], 4'h7});
            wb(1'b1, 6'h00, 8'h00);
            wb(1'b1, 6'h0b, 8'h00);
            rd(6'h0b, {2'b00, m[1:0], 1'b0, hit[2:0]});
            repeat (24) begin
                p = $urandom % 8 & ((m == 0) ? 4 : (m == 1) ? 6 : 7);
                for (i = 0; i < 4; i++) id[31-8*i -: 8] = code[(p+i)%8] ^ ($urandom & mask[(p+i)%8]);
                if ($urandom % 4 == 0) id = id ^ (32'h1 << ($urandom % 32));
                ext = $urandom;
                h = find_hit(id, ext);
                u_can_node_model.frame(id, ext);
                @(negedge clk_i);
                if (h >= 0) {front, hit} = {id, h};
                chk("accept", {31'h0, h >= 0}, {31'h0, rx_accept_o});
                chk("back ident", id, rx_back_ident_o);
                chk("front ident", front, rx_front_ident_o);
                rd(6'h0b, {2'b00, m[1:0], 1'b0, hit[2:0]});
            end
        end
        report_and_stop;
    end
endmodule // testbench

// ===== verilog/can_txsel_acceptance_filter.v
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ns
`include "can_consts.vh"

// Operation
// - Clearing a send-slot-empty flag also clears its abort-done flag.
// - Abort-done 1 means aborted on request; 0 means sent anyway.
// - Abort-done flags are read-only and held reset during init mode.
// - Lowest set select bit maps its send buffer into the shared window.
// - Select register reads back only its lowest set bit.
// - Window access blocked while selected buffer is scheduled (empty flag clear).
// - No window access when no send buffer is selected.
// - Select register held reset in init mode, writable after leaving.
// - Mode field: 00 two 32-bit, 01 four 16-bit, 10 eight 8-bit, 11 closed.
// - Closed filter accepts nothing; front receive buffer never reloaded.
// - Acceptance control readable always, writable in init only, hit bits read-only.
// - Matching filter reported as three-bit index, 000 filter 0 to 111 filter 7.
// - Hit index describes front buffer message, updated when a message moves in.
// - Reserved test registers read zero and ignore writes.
// - Error counters not writable; valid reads only in sleep or init mode.
// - Every message lands in background buffer; only accepted ones are signalled.
// - Bitwise identifier compare; in 32-bit mode extended uses four bytes, standard two.
// - Mask 1 ignores the bit, mask 0 needs equality; all unmasked must match.
// - Code and mask reset to zero, read always, written only in init mode.
// - Empty flag set after successful send or after a granted abort.
// - Abort granted only if transmission not started or it failed.
module can_txsel_acceptance_filter #(
    parameter NBUF = 3,
    parameter WIN  = 16
) (
    // Clock and reset
    input  wire         clk_i,
    input  wire         rst_i,
    // Wishbone slave
    input  wire         cyc_i,
    input  wire         stb_i,
    input  wire         we_i,
    input  wire [7:0]   adr_i,
    input  wire [3:0]   sel_i,
    input  wire [31:0]  dat_i,
    output wire [31:0]  dat_o,
    output wire         ack_o,
    // Transmit scheduler
    input  wire [2:0]   tx_done_i,
    input  wire [2:0]   tx_busy_i,
    input  wire [2:0]   tx_fail_i,
    input  wire [5:0]   tx_rd_addr_i,
    output wire [7:0]   tx_rd_data_o,
    output wire [2:0]   tx_pending_o,
    // Receiver
    input  wire         rx_valid_i,
    input  wire [31:0]  rx_ident_i,
    input  wire         rx_ext_i,
    output wire [31:0]  rx_back_ident_o,
    output wire [31:0]  rx_front_ident_o,
    output wire         rx_accept_o,
    // Error counters from the bit engine
    input  wire [7:0]   rx_err_count_i,
    input  wire [7:0]   tx_err_count_i,
    // Mode status
    output wire         init_mode_o,
    output wire         sleep_mode_o
);

    // ==========================================================
    // State
    reg  [31:0] dat_reg;
    reg         ack_reg;
    reg         init_request_reg;
    reg         init_acknowledge_reg;
    reg         sleep_request_reg;
    reg         sleep_acknowledge_reg;
    reg  [2:0]  send_slot_empty_reg;
    reg  [2:0]  send_slot_empty_next;
    reg  [2:0]  abort_request_reg;
    reg  [2:0]  abort_request_next;
    reg  [2:0]  abort_done_reg;
    reg  [2:0]  abort_done_next;
    reg  [2:0]  send_select_reg;
    reg  [1:0]  filter_mode_reg;
    reg  [2:0]  filter_hit_reg;
    reg  [7:0]  accept_code_reg [0:7];
    reg  [7:0]  accept_mask_reg [0:7];
    reg  [7:0]  send_mem [0:NBUF*WIN-1];
    reg  [7:0]  tx_rd_data_reg;
    reg  [2:0]  tx_pending_reg;
    reg  [31:0] rx_back_reg;
    reg  [31:0] rx_front_reg;
    reg         rx_accept_reg;

    // ==========================================================
    // Decode
    wire        bus_req    = cyc_i & stb_i & ~ack_reg;
    wire        bus_wr     = bus_req & we_i & sel_i[0];
    wire [5:0]  idx        = adr_i[`IDX_HI:`IDX_LO];
    wire [7:0]  wbyte      = dat_i[7:0];
    wire        init_mode  = init_request_reg & init_acknowledge_reg;
    wire        sleep_mode = sleep_request_reg & sleep_acknowledge_reg;
    wire        filt_hit   = (idx[5:4] == `FILT_SPACE);
    wire        win_hit    = (idx[5:4] == `WIN_SPACE);
    wire [2:0]  filt_slot  = {idx[3], idx[1:0]};
    wire        filt_mask  = idx[2];

    // Lowest set select bit wins
    reg  [2:0]  select_low;
    reg  [1:0]  select_num;
    always @* begin
        select_low = `THREE_ZERO;
        select_num = 2'h0;
        if (send_select_reg[0]) begin
            select_low = 3'h1;
            select_num = 2'h0;
        end else if (send_select_reg[1]) begin
            select_low = 3'h2;
            select_num = 2'h1;
        end else if (send_select_reg[2]) begin
            select_low = 3'h4;
            select_num = 2'h2;
        end
    end

    // Window open only for a selected buffer that is not queued
    wire        win_open = (|select_low) & (|(select_low & send_slot_empty_reg));
    wire [5:0]  win_addr = {select_num, idx[`WIN_IDX_W-1:0]};

    // ==========================================================
    // Acceptance filter lanes
    wire [7:0]  lane_match;
    genvar k;
    generate
        for (k = 0; k < 8; k = k + 1) begin : g_lane
            // Lane byte choice follows the filter width
            wire [1:0] byte_sel = (filter_mode_reg == `FMODE_32) ? k[1:0] :
                                  (filter_mode_reg == `FMODE_16) ? {1'b0, k[0]} : 2'h0;
            wire [7:0] id_byte  = rx_ident_i[31 - 8 * byte_sel -: 8];
            id_byte_match #(
                .W       (8)
            ) u_lane (
                .code_i  (accept_code_reg[k]),
                .mask_i  (accept_mask_reg[k]),
                .ident_i (id_byte),
                .match_o (lane_match[k])
            );
        end
    endgenerate

    // Filter hit vector for the active arrangement
    reg  [7:0]  hit_vec;
    reg  [2:0]  hit_num;
    integer     f;
    always @* begin
        hit_vec = 8'h00;
        hit_num = `THREE_ZERO;
        case (filter_mode_reg)
            `FMODE_32: begin
                for (f = 0; f < 2; f = f + 1)
                    hit_vec[f] = lane_match[4*f] & lane_match[4*f+1] &
                                 (~rx_ext_i | (lane_match[4*f+2] & lane_match[4*f+3]));
            end
            `FMODE_16: begin
                for (f = 0; f < 4; f = f + 1)
                    hit_vec[f] = lane_match[2*f] & lane_match[2*f+1];
            end
            `FMODE_8: begin
                hit_vec = lane_match;
            end
            default: begin
                hit_vec = 8'h00;
            end
        endcase
        // Lowest numbered filter is reported
        for (f = 7; f >= 0; f = f - 1)
            if (hit_vec[f])
                hit_num = f[2:0];
    end

    wire        accept = rx_valid_i & (|hit_vec);

    // ==========================================================
    // Mode request and acknowledge
    always @(posedge clk_i) begin
        if (rst_i) begin
            init_request_reg      <= 1'b0;
            init_acknowledge_reg  <= 1'b0;
            sleep_request_reg     <= 1'b0;
            sleep_acknowledge_reg <= 1'b0;
        end else begin
            if (bus_wr && idx == `IDX_MODE_CTRL) begin
                init_request_reg  <= wbyte[`CTRL_INIT_BIT];
                sleep_request_reg <= wbyte[`CTRL_SLEEP_BIT];
            end
            // Acknowledge follows the request one cycle later
            init_acknowledge_reg  <= init_request_reg;
            sleep_acknowledge_reg <= sleep_request_reg;
        end
    end

    // ==========================================================
    // Send flags, abort requests and abort-done flags
    integer     b;
    always @* begin
        send_slot_empty_next = send_slot_empty_reg;
        abort_request_next   = abort_request_reg;
        abort_done_next      = abort_done_reg;
        for (b = 0; b < NBUF; b = b + 1) begin
            // Software clear first, so hardware set wins below
            if (bus_wr && idx == `IDX_SEND_FLAGS && wbyte[b]) begin
                send_slot_empty_next[b] = 1'b0;
                abort_done_next[b]      = 1'b0;
            end
            if (bus_wr && idx == `IDX_ABORT_REQ && wbyte[b] && !send_slot_empty_reg[b])
                abort_request_next[b] = 1'b1;
            if (!send_slot_empty_reg[b] && tx_done_i[b]) begin
                send_slot_empty_next[b] = 1'b1;
                abort_done_next[b]      = 1'b0;
                abort_request_next[b]   = 1'b0;
            end else if (!send_slot_empty_reg[b] && abort_request_reg[b] &&
                         (!tx_busy_i[b] || tx_fail_i[b])) begin
                send_slot_empty_next[b] = 1'b1;
                abort_done_next[b]      = 1'b1;
                abort_request_next[b]   = 1'b0;
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i || init_mode) begin
            send_slot_empty_reg <= `SEND_FLAGS_RST;
            abort_request_reg   <= `THREE_ZERO;
            abort_done_reg      <= `THREE_ZERO;
            send_select_reg     <= `THREE_ZERO;
        end else begin
            send_slot_empty_reg <= send_slot_empty_next;
            abort_request_reg   <= abort_request_next;
            abort_done_reg      <= abort_done_next;
            if (bus_wr && idx == `IDX_SEND_SELECT)
                send_select_reg <= wbyte[2:0];
        end
    end

    // ==========================================================
    // Filter setup, writable only in init mode
    integer     r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            filter_mode_reg <= `FMODE_32;
            for (r = 0; r < 8; r = r + 1) begin
                accept_code_reg[r] <= `BYTE_RST;
                accept_mask_reg[r] <= `BYTE_RST;
            end
        end else if (bus_wr && init_mode) begin
            if (idx == `IDX_ACC_CTRL)
                filter_mode_reg <= wbyte[`ACC_MODE_HI:`ACC_MODE_LO];
            if (filt_hit && filt_mask)
                accept_mask_reg[filt_slot] <= wbyte;
            if (filt_hit && !filt_mask)
                accept_code_reg[filt_slot] <= wbyte;
        end
    end

    // ==========================================================
    // Receive path: background always, front only on acceptance
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_back_reg    <= 32'h0;
            rx_front_reg   <= 32'h0;
            filter_hit_reg <= `THREE_ZERO;
            rx_accept_reg  <= 1'b0;
        end else begin
            rx_accept_reg <= accept;
            if (rx_valid_i)
                rx_back_reg <= rx_ident_i;
            if (accept) begin
                rx_front_reg   <= rx_ident_i;
                filter_hit_reg <= hit_num;
            end
        end
    end

    // ==========================================================
    // Send buffer window storage; contents undefined after reset
    always @(posedge clk_i) begin
        if (bus_wr && win_hit && win_open)
            send_mem[win_addr] <= wbyte;
    end

    // Scheduler read port and pending view
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_rd_data_reg <= `BYTE_RST;
            tx_pending_reg <= `THREE_ZERO;
        end else begin
            tx_rd_data_reg <= send_mem[tx_rd_addr_i];
            tx_pending_reg <= ~send_slot_empty_reg;
        end
    end

    // ==========================================================
    // Read multiplexer
    reg  [7:0]  rd_byte;
    always @* begin
        rd_byte = `BYTE_RST;
        if (filt_hit) begin
            rd_byte = filt_mask ? accept_mask_reg[filt_slot] : accept_code_reg[filt_slot];
        end else if (win_hit) begin
            rd_byte = win_open ? send_mem[win_addr] : `BYTE_RST;
        end else begin
            case (idx)
                `IDX_MODE_CTRL:   rd_byte = {6'h0, sleep_request_reg, init_request_reg};
                `IDX_MODE_STAT:   rd_byte = {6'h0, sleep_acknowledge_reg, init_acknowledge_reg};
                `IDX_SEND_FLAGS:  rd_byte = {5'h0, send_slot_empty_reg};
                `IDX_ABORT_REQ:   rd_byte = {5'h0, abort_request_reg};
                `IDX_ABORT_DONE:  rd_byte = {5'h0, abort_done_reg};
                `IDX_SEND_SELECT: rd_byte = {5'h0, select_low};
                `IDX_ACC_CTRL:    rd_byte = {2'h0, filter_mode_reg, 1'b0, filter_hit_reg};
                `IDX_TEST_0:      rd_byte = `BYTE_RST;
                `IDX_TEST_1:      rd_byte = `BYTE_RST;
                // Live count is not stable outside a quiet mode
                `IDX_RX_ERR:      rd_byte = (init_mode | sleep_mode) ? rx_err_count_i : `BYTE_RST;
                `IDX_TX_ERR:      rd_byte = (init_mode | sleep_mode) ? tx_err_count_i : `BYTE_RST;
                default:          rd_byte = `BYTE_RST;
            endcase
        end
    end

    // ==========================================================
    // Bus answer: one cycle after the request is seen
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end else begin
            ack_reg <= bus_req;
            if (bus_req)
                dat_reg <= {24'h0, rd_byte};
        end
    end

    // ==========================================================
    // Outputs
    assign dat_o            = dat_reg;
    assign ack_o            = ack_reg;
    assign tx_rd_data_o     = tx_rd_data_reg;
    assign tx_pending_o     = tx_pending_reg;
    assign rx_back_ident_o  = rx_back_reg;
    assign rx_front_ident_o = rx_front_reg;
    assign rx_accept_o      = rx_accept_reg;
    assign init_mode_o      = init_acknowledge_reg;
    assign sleep_mode_o     = sleep_acknowledge_reg;

endmodule // can_txsel_acceptance_filter

// ===== verilog/id_byte_match.v
`timescale 1ns/1ns

// ==========================================================
// One lane of the acceptance filter
module id_byte_match #(
    parameter W = 8
) (
    // Lane operands
    input  wire [W-1:0] code_i,
    input  wire [W-1:0] mask_i,
    input  wire [W-1:0] ident_i,
    // Result
    output wire         match_o
);

    // Set mask bit makes the bit a don't-care
    assign match_o = &(mask_i | ~(code_i ^ ident_i));

endmodule // id_byte_match
